// ---- verilog/tswdp_pkg.sv ----
// Package of constants and types for the two-stage watchdog pulse block
package tswdp_pkg;
  // Register offsets
  localparam logic [7:0] OFF_CLK_SEL   = 8'hE7;
  localparam logic [7:0] OFF_PULSE_CNT = 8'hE8;
  localparam logic [7:0] OFF_TIME_CNT  = 8'hEB;
  localparam logic [7:0] OFF_START     = 8'hED;
  localparam logic [7:0] OFF_MASK      = 8'hF0;
  localparam logic [7:0] OFF_STATUS    = 8'hF3;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'hF4;
  // Reset values
  localparam logic [7:0] RST_CLK_SEL   = 8'h00;
  localparam logic [7:0] RST_PULSE_CNT = 8'h32;
  localparam logic [7:0] RST_TIME_CNT  = 8'h14;
  localparam logic [7:0] RST_START     = 8'h00;
  localparam logic [7:0] RST_MASK      = 8'h00;
  localparam logic [7:0] RST_STATUS    = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK  = 8'h00;
  // Field positions
  localparam int BIT_START      = 0;
  localparam int BIT_TIMEOUT    = 7;
  localparam int BIT_SWAP       = 0;
  localparam int BIT_M1_PGOOD   = 7;
  localparam int BIT_M1_RSTCON  = 6;
  localparam int BIT_MM_PGOOD   = 4;
  localparam int BIT_MM_RSTCON  = 3;
  localparam int BIT_M1_RESUME  = 0;
  localparam int FLD_STAGE1_LSB = 2;
  localparam int FLD_STAGE2_LSB = 0;
  // Clock rates and tick periods in cycles of the 200 MHz clock
  localparam longint CLK_HZ    = 200000000;
  localparam longint HZ_4      = 4;
  localparam longint HZ_1      = 1;
  localparam longint HZ_1M     = 1000000;
  localparam longint HZ_512    = 512;
  localparam longint HZ_256    = 256;
  localparam longint HZ_1K     = 1000;
  localparam longint CYC_4HZ   = CLK_HZ / HZ_4;
  localparam longint CYC_1HZ   = CLK_HZ / HZ_1;
  localparam longint CYC_HALF  = 2 * CLK_HZ / HZ_1;
  localparam longint CYC_1MHZ  = CLK_HZ / HZ_1M;
  localparam longint CYC_512HZ = CLK_HZ / HZ_512;
  localparam longint CYC_256HZ = CLK_HZ / HZ_256;
  localparam longint CYC_1KHZ  = CLK_HZ / HZ_1K;
  localparam int PRE_W = 30;
  // State machine of the watchdog
  typedef enum logic [1:0] {
    TSWDP_IDLE,
    TSWDP_COUNT,
    TSWDP_PULSE
  } tswdp_state_t;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tswdp_bus_t;
  // Mask-gated effects of the watchdogs
  typedef struct packed {
    logic pgood;
    logic deep_off;
    logic rstcon;
    logic resume;
  } tswdp_fx_t;
endpackage : tswdp_pkg

// ---- verilog/tswdp_top.sv ----
// Two-stage watchdog with pulse output, effect mask and register port
`timescale 1ns/1ps
module tswdp_top (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_first_watchdog_evt,
  input  wire logic       i_memory_watchdog_evt,
  input  wire logic       i_keyboard_controller_swap,
  output logic      [7:0] o_rdata,
  output logic            o_second_watchdog_pulse_n,
  output logic            o_power_good_output_kill,
  output logic            o_deep_soft_off_state_req,
  output logic            o_reset_connector_output_req,
  output logic            o_resume_reset_req,
  output logic            o_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State carrier

  typedef struct packed {
    tswdp_pkg::tswdp_state_t     st;
    logic [7:0]                  clk_sel;
    logic [7:0]                  pulse_cnt;
    logic [7:0]                  time_cnt;
    logic                        start;
    logic [7:0]                  mask;
    logic                        timeout;
    logic                        irq_mask;
    logic [tswdp_pkg::PRE_W-1:0] pre;
    logic [7:0]                  ticks;
    logic [2:0]                  swap_sync;
    logic                        swap;
    logic [7:0]                  rdata;
    logic                        pulse_n;
    tswdp_pkg::tswdp_fx_t        fx;
    logic                        irq;
  } tswdp_regs_t;

  tswdp_regs_t        s_reg;
  tswdp_regs_t        s_next;
  tswdp_pkg::tswdp_bus_t bus;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  ////////////////////////////////////////////////////////////////////////////////
  // Tick period in cycles for a stage and its select code

  function automatic logic [tswdp_pkg::PRE_W-1:0] tick_cycles(input logic stage2,
                                                             input logic [1:0] sel);
    logic [tswdp_pkg::PRE_W-1:0] c;
    c = '0;
    if (!stage2) begin
      case (sel)
        2'h0:    c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_4HZ);
        2'h1:    c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_1HZ);
        2'h2:    c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_HALF);
        default: c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_1MHZ);
      endcase
    end else begin
      case (sel)
        2'h0:    c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_512HZ);
        2'h1:    c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_256HZ);
        2'h2:    c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_1KHZ);
        default: c = tswdp_pkg::PRE_W'(tswdp_pkg::CYC_1MHZ);
      endcase
    end
    return c;
  endfunction : tick_cycles

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic                        tick;
    logic                        wr_start;
    logic [tswdp_pkg::PRE_W-1:0] period;
    logic [7:0]                  status;
    tick     = 1'b0;
    wr_start = 1'b0;
    period   = '0;
    status   = '0;
    s_next   = s_reg;

    // Keyboard swap strap from another domain: three flops, accept when last two agree
    s_next.swap_sync = {s_reg.swap_sync[1:0], i_keyboard_controller_swap};
    if (s_reg.swap_sync[2] == s_reg.swap_sync[1]) begin
      s_next.swap = s_reg.swap_sync[2];
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        tswdp_pkg::OFF_CLK_SEL:   s_next.clk_sel   = {4'h0, bus.wdata[3:0]};
        tswdp_pkg::OFF_PULSE_CNT: s_next.pulse_cnt = bus.wdata;
        tswdp_pkg::OFF_TIME_CNT:  s_next.time_cnt  = bus.wdata;
        tswdp_pkg::OFF_START: begin
          s_next.start = bus.wdata[tswdp_pkg::BIT_START];
          wr_start     = bus.wdata[tswdp_pkg::BIT_START];
        end
        tswdp_pkg::OFF_MASK:      s_next.mask      = bus.wdata & 8'hD9;
        tswdp_pkg::OFF_STATUS: begin
          // Only a written zero clears; a new start leaves the flag alone
          if (!bus.wdata[tswdp_pkg::BIT_TIMEOUT]) begin
            s_next.timeout = 1'b0;
          end
        end
        tswdp_pkg::OFF_IRQ_MASK:  s_next.irq_mask  = bus.wdata[tswdp_pkg::BIT_TIMEOUT];
        default: ;
      endcase
    end

    // Prescaler shared by both stages; a tick ends each period
    period = tick_cycles(s_reg.st == tswdp_pkg::TSWDP_PULSE,
                         (s_reg.st == tswdp_pkg::TSWDP_PULSE)
                           ? s_reg.clk_sel[tswdp_pkg::FLD_STAGE2_LSB +: 2]
                           : s_reg.clk_sel[tswdp_pkg::FLD_STAGE1_LSB +: 2]);
    if (s_reg.pre >= period - 1'b1) begin
      tick       = 1'b1;
      s_next.pre = '0;
    end else begin
      s_next.pre = s_reg.pre + 1'b1;
    end

    // Watchdog sequence
    case (s_reg.st)
      tswdp_pkg::TSWDP_IDLE: begin
        s_next.pre   = '0;
        s_next.ticks = '0;
        if (wr_start) begin
          s_next.st = tswdp_pkg::TSWDP_COUNT;
        end
      end
      tswdp_pkg::TSWDP_COUNT: begin
        if (bus.wr && bus.addr == tswdp_pkg::OFF_START && !wr_start) begin
          s_next.st = tswdp_pkg::TSWDP_IDLE;
        end else if (tick) begin
          // Count of ticks times the stage-one period
          if (s_reg.ticks + 8'h01 >= s_reg.time_cnt) begin
            s_next.st      = tswdp_pkg::TSWDP_PULSE;
            s_next.ticks   = '0;
            s_next.pre     = '0;
            s_next.pulse_n = 1'b0;
            s_next.timeout = 1'b1;
          end else begin
            s_next.ticks = s_reg.ticks + 8'h01;
          end
        end
      end
      tswdp_pkg::TSWDP_PULSE: begin
        // Pulse lasts pulse count times the stage-two period
        if (tick) begin
          if (s_reg.ticks + 8'h01 >= s_reg.pulse_cnt) begin
            s_next.st      = tswdp_pkg::TSWDP_IDLE;
            s_next.pulse_n = 1'b1;
            s_next.start   = 1'b0;
            s_next.ticks   = '0;
          end else begin
            s_next.ticks = s_reg.ticks + 8'h01;
          end
        end
      end
      default: s_next.st = tswdp_pkg::TSWDP_IDLE;
    endcase

    // Effects of the other watchdogs, gated by mask bits; deep off follows the first-watchdog power good bit
    s_next.fx.pgood    = (i_first_watchdog_evt & s_reg.mask[tswdp_pkg::BIT_M1_PGOOD])
                       | (i_memory_watchdog_evt & s_reg.mask[tswdp_pkg::BIT_MM_PGOOD]);
    s_next.fx.deep_off = i_first_watchdog_evt & s_reg.mask[tswdp_pkg::BIT_M1_PGOOD];
    s_next.fx.rstcon   = (i_first_watchdog_evt & s_reg.mask[tswdp_pkg::BIT_M1_RSTCON])
                       | (i_memory_watchdog_evt & s_reg.mask[tswdp_pkg::BIT_MM_RSTCON]);
    s_next.fx.resume   = i_first_watchdog_evt & s_reg.mask[tswdp_pkg::BIT_M1_RESUME];

    // Read data, valid one cycle after the strobe
    status = {s_reg.timeout, 6'h00, s_reg.swap};
    s_next.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        tswdp_pkg::OFF_CLK_SEL:   s_next.rdata = s_reg.clk_sel;
        tswdp_pkg::OFF_PULSE_CNT: s_next.rdata = s_reg.pulse_cnt;
        tswdp_pkg::OFF_TIME_CNT:  s_next.rdata = s_reg.time_cnt;
        tswdp_pkg::OFF_START:     s_next.rdata = {7'h00, s_reg.start};
        tswdp_pkg::OFF_MASK:      s_next.rdata = s_reg.mask;
        tswdp_pkg::OFF_STATUS:    s_next.rdata = status;
        tswdp_pkg::OFF_IRQ_MASK:  s_next.rdata = {s_reg.irq_mask, 7'h00};
        default:                  s_next.rdata = 8'h00;
      endcase
    end

    s_next.irq = s_next.timeout & s_next.irq_mask;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_reg           <= '0;
      s_reg.st        <= tswdp_pkg::TSWDP_IDLE;
      s_reg.clk_sel   <= tswdp_pkg::RST_CLK_SEL;
      s_reg.pulse_cnt <= tswdp_pkg::RST_PULSE_CNT;
      s_reg.time_cnt  <= tswdp_pkg::RST_TIME_CNT;
      s_reg.start     <= tswdp_pkg::RST_START[0];
      s_reg.mask      <= tswdp_pkg::RST_MASK;
      s_reg.timeout   <= tswdp_pkg::RST_STATUS[7];
      s_reg.irq_mask  <= tswdp_pkg::RST_IRQ_MASK[7];
      s_reg.pulse_n   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata                      = s_reg.rdata;
  assign o_second_watchdog_pulse_n    = s_reg.pulse_n;
  assign o_power_good_output_kill     = s_reg.fx.pgood;
  assign o_deep_soft_off_state_req    = s_reg.fx.deep_off;
  assign o_reset_connector_output_req = s_reg.fx.rstcon;
  assign o_resume_reset_req           = s_reg.fx.resume;
  assign o_irq                        = s_reg.irq;

endmodule : tswdp_top

// ---- tb/tswdp_partner.sv ----
// Model of the platform reset circuit that receives the watchdog pulse
`timescale 1ns/1ps
module tswdp_partner (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_pulse_n,
  output logic      [15:0] o_last_width,
  output logic      [7:0]  o_pulse_count
);
  logic [15:0] low_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // Width of each low pulse is latched at its rising end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      low_reg       <= 16'h0000;
      o_last_width  <= 16'h0000;
      o_pulse_count <= 8'h00;
    end else if (!i_pulse_n) begin
      low_reg <= low_reg + 16'h0001;
    end else begin
      if (low_reg != 16'h0000) begin
        o_last_width  <= low_reg;
        o_pulse_count <= o_pulse_count + 8'h01;
      end
      low_reg <= 16'h0000;
    end
  end
endmodule : tswdp_partner

// ---- tb/tswdp_props.sv ----
// Port checker of the two-stage watchdog pulse block
`timescale 1ns/1ps
module tswdp_props (
  input wire logic       i_clock,
  input wire logic       i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_first_watchdog_evt,
  input wire logic       i_memory_watchdog_evt,
  input wire logic       i_keyboard_controller_swap,
  input wire logic [7:0] o_rdata,
  input wire logic       o_second_watchdog_pulse_n,
  input wire logic       o_power_good_output_kill,
  input wire logic       o_deep_soft_off_state_req,
  input wire logic       o_reset_connector_output_req,
  input wire logic       o_resume_reset_req,
  input wire logic       o_irq
);
  logic [7:0]  mask_sh;
  logic [7:0]  pw_sh;
  logic [1:0]  sel_sh;
  logic        irqm_sh;
  logic [1:0]  clr_sh;
  logic [15:0] low_cnt;
  logic        f_c;
  logic        m_c;
  logic        clr_now;
  logic [15:0] pw_exp;
  ////////////////////////////////////////////////////////////////////////////////
  // Causes seen at the inputs, through shadows of the written registers
  assign f_c     = i_first_watchdog_evt;
  assign m_c     = i_memory_watchdog_evt;
  assign clr_now = i_wr && (i_addr == 8'hF3 || i_addr == 8'hF4);
  // Count zero behaves as one
  assign pw_exp  = ((pw_sh == 8'h00) ? 16'h0001 : {8'h00, pw_sh}) * 16'h00C8;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mask_sh <= 8'h00;
      pw_sh   <= 8'h32;
      sel_sh  <= 2'h0;
      irqm_sh <= 1'b0;
      clr_sh  <= 2'h0;
      low_cnt <= 16'h0000;
    end else begin
      if (i_wr && i_addr == 8'hF0) mask_sh <= i_wdata;
      if (i_wr && i_addr == 8'hE8) pw_sh <= i_wdata;
      if (i_wr && i_addr == 8'hE7) sel_sh <= i_wdata[1:0];
      if (i_wr && i_addr == 8'hF4) irqm_sh <= i_wdata[7];
      clr_sh  <= {clr_sh[0], clr_now};
      low_cnt <= o_second_watchdog_pulse_n ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Each property is declared ahead of the assertion that uses it
  property p_rdata_idle;
    @(posedge i_clock) disable iff (i_sys_rst) !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // bus data only after a read
    else $error("read data not zero outside read answer");
  property p_pgood;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_power_good_output_kill == $past((f_c & mask_sh[7]) | (m_c & mask_sh[4]));
  endproperty
  a_pgood: assert property (p_pgood)
    else $error("power good action does not follow cause");
  property p_deep;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_deep_soft_off_state_req == $past(f_c & mask_sh[7]);
  endproperty
  a_deep: assert property (p_deep)
    else $error("deep off request does not follow cause");
  property p_rstcon;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_reset_connector_output_req == $past((f_c & mask_sh[6]) | (m_c & mask_sh[3]));
  endproperty
  a_rstcon: assert property (p_rstcon)
    else $error("reset connector action does not follow cause");
  property p_resume;
    @(posedge i_clock) disable iff (i_sys_rst) o_resume_reset_req == $past(f_c & mask_sh[0]);
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume reset action does not follow cause");
  property p_irq_set;
    @(posedge i_clock) disable iff (i_sys_rst)
      $fell(o_second_watchdog_pulse_n) && irqm_sh |-> ##[0:2] o_irq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("timeout did not raise interrupt");
  property p_irq_hold;
    @(posedge i_clock) disable iff (i_sys_rst) $fell(o_irq) |-> clr_now || clr_sh != 2'h0;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without software clear");
  property p_width;
    @(posedge i_clock) disable iff (i_sys_rst)
      $rose(o_second_watchdog_pulse_n) && sel_sh == 2'h3 |->
        low_cnt + 16'h0002 >= pw_exp && low_cnt <= pw_exp + 16'h0002;
  endproperty
  a_width: assert property (p_width)
    else $error("pulse width wrong");
endmodule : tswdp_props
bind tswdp_top tswdp_props u_props (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_first_watchdog_evt(i_first_watchdog_evt),
  .i_memory_watchdog_evt(i_memory_watchdog_evt),
  .i_keyboard_controller_swap(i_keyboard_controller_swap), .o_rdata(o_rdata),
  .o_second_watchdog_pulse_n(o_second_watchdog_pulse_n),
  .o_power_good_output_kill(o_power_good_output_kill),
  .o_deep_soft_off_state_req(o_deep_soft_off_state_req),
  .o_reset_connector_output_req(o_reset_connector_output_req),
  .o_resume_reset_req(o_resume_reset_req), .o_irq(o_irq));

// ---- tb/tswdp_top_bench.sv ----
// Register-level testbench of the two-stage watchdog pulse block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tswdp_top_bench;
  logic i_clock, i_sys_rst, i_wr, i_rd, fe, me, sw, pn, kl, dp, rc, rs, o_irq;
  logic [7:0]  i_addr, i_wdata, o_rdata, pcnt, m;
  logic [15:0] wid;
  int          miscompares, cmp_count, d;
  logic [3:0]  ex;
  logic [7:0]  ra[8] = '{8'hE7, 8'hE8, 8'hEB, 8'hED, 8'hF0, 8'hF3, 8'hF4, 8'h55};
  logic [7:0]  re[8] = '{8'h00, 8'h32, 8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  mk[7] = '{8'hD9, 8'h80, 8'h40, 8'h10, 8'h08, 8'h01, 8'h00};
  tswdp_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_first_watchdog_evt(fe),
    .i_memory_watchdog_evt(me), .i_keyboard_controller_swap(sw), .o_rdata(o_rdata),
    .o_second_watchdog_pulse_n(pn), .o_power_good_output_kill(kl),
    .o_deep_soft_off_state_req(dp), .o_reset_connector_output_req(rc),
    .o_resume_reset_req(rs), .o_irq(o_irq));
  tswdp_partner u_plat (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pulse_n(pn),
    .o_last_width(wid), .o_pulse_count(pcnt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask : rd_chk
  // Start, then time the delay to the pulse and wait for its end
  task automatic run_wd(input logic [7:0] pc);
    wr_reg(8'hE8, pc);
    wr_reg(8'hED, 8'h01);
    // Look just after each edge, once the registered pulse has settled
    for (d = 0; pn === 1'b1 && d < 3000; d++) @(posedge i_clock) #1;
    for (int n = 0; pn !== 1'b1 && n < 60000; n++) @(posedge i_clock) #1;
    repeat (2) @(posedge i_clock);
  endtask : run_wd
  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  // Hang guard: the whole sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    end_of_test();
  end
  initial begin
    {i_sys_rst, i_addr, i_wdata, i_wr, i_rd, fe, me, sw} = {1'b1, 21'h0};
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd_chk(ra[i], re[i]);
    wr_reg(8'h55, 8'hAA);
    rd_chk(8'h55, 8'h00);
    wr_reg(8'hF0, 8'hFF);
    rd_chk(8'hF0, 8'hD9);
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'hF0, mk[i]);
      m = mk[i];
      for (int j = 0; j < 4; j++) begin
        @(posedge i_clock);
        {fe, me} <= j[1:0];
        repeat (3) @(posedge i_clock);
        #1 ex = {fe & m[7] | me & m[4], fe & m[7], fe & m[6] | me & m[3], fe & m[0]};
        `CHK({kl, dp, rc, rs}, ex)
      end
    end
    @(posedge i_clock);
    {fe, me, sw} <= 3'h1;
    repeat (6) @(posedge i_clock);
    rd_chk(8'hF3, 8'h01);
    wr_reg(8'hE7, 8'hFF);
    rd_chk(8'hE7, 8'h0F);
    wr_reg(8'hEB, 8'h02);
    wr_reg(8'hF4, 8'h80);
    run_wd(8'h02);
    `CHK(8'((d + 5) / 10), 8'h28)
    `CHK(wid / 16'h000A, 16'h0028)
    rd_chk(8'hED, 8'h00);
    rd_chk(8'hF3, 8'h81);
    `CHK(o_irq, 1'b1)
    wr_reg(8'hF3, 8'h80);
    rd_chk(8'hF3, 8'h81);
    wr_reg(8'hF3, 8'h00);
    rd_chk(8'hF3, 8'h01);
    `CHK(o_irq, 1'b0)
    run_wd(8'h00);
    `CHK(wid / 16'h000A, 16'h0014)
    wr_reg(8'hED, 8'h01);
    repeat (100) @(posedge i_clock);
    wr_reg(8'hED, 8'h00);
    repeat (800) @(posedge i_clock);
    `CHK(pcnt, 8'h02)
    rd_chk(8'hED, 8'h00);
    // Reset with the watchdog stopped, held two edges so no edge check sees a stale cycle
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd_chk(ra[i], re[i]);
    end_of_test();
  end
endmodule : tswdp_top_bench
